/* ifb_top.sv */
module ifb_top import ifb_pkg::*; #(
    parameter int FETCH_CP = IFB_FETCH_CP
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CUR_TWO_PARCEL,
    input wire logic ISSUE_HOLD,
    output logic ISSUE_GO,
    output logic [IFB_PCL_W-1:0] CUR_PARCEL,
    output logic [IFB_PCL_W-1:0] LOW_PARCEL,
    output logic CUR_VALID,
    input wire logic BRANCH_TAKEN,
    input wire logic [IFB_PA_W-1:0] BRANCH_ADDR,
    input wire logic XCHG_GO,
    input wire logic XCHG_ACTIVE,
    input wire logic [IFB_PA_W-1:0] XCHG_P_IN,
    output logic [IFB_PA_W-1:0] XCHG_P_OUT,
    output logic LOCKOUT,
    input wire logic MEM_BUSY,
    output logic MEM_REQ,
    output logic [IFB_WA_W-1:0] MEM_ADDR,
    input wire logic MEM_RVALID,
    input wire logic [IFB_GRP_N*IFB_PCL_W-1:0] MEM_RDATA
);
    // parcel registers; data holders have no reset
    logic [IFB_PA_W-1:0] p_ff;
    logic [IFB_PCL_W-1:0] next_parcel_reg;
    logic [IFB_PCL_W-1:0] current_parcel_reg;
    logic [IFB_PCL_W-1:0] lower_parcel_reg;
    logic nip_vld_ff, cip_vld_ff, lip_vld_ff;
    logic [IFB_PCL_W-1:0] mem_ff [IFB_NBUF*IFB_DEPTH];
    logic [IFB_TAG_W-1:0] tag_ff [IFB_NBUF];
    logic [IFB_NBUF-1:0] tvld_ff;
    logic [IFB_NGRP-1:0] gok_ff [IFB_NBUF];
    logic [1:0] rot_ff, fbuf_ff, fgrp_ff, last_buf_ff, sw_cnt_ff;
    logic [2:0] qcnt_ff, rcnt_ff;
    logic [IFB_TAG_W-1:0] ftag_ff;
    ifb_fsm_e fsm_ff;
    logic mem_req_ff;
    logic [IFB_WA_W-1:0] mem_addr_ff;
    logic [7:0] lat_ff;
    logic late_ff;
    logic [31:0] ctrl_ff;
    logic inv_ff;
    logic aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
    logic [3:0] aw_addr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [1:0] bresp_ff, rresp_ff;

    logic [IFB_NBUF-1:0] match;
    logic hit, grp_rdy, sw_need, want, to_lip, fetch_go;
    logic cip_take, miss_go, flush, wr_go;
    logic [1:0] hit_idx;
    logic [IFB_TAG_W-1:0] p_tag;
    logic [1:0] p_grp;

    assign p_tag = p_ff[IFB_PA_W-1:IFB_TAG_LSB];
    assign p_grp = p_ff[IFB_TAG_LSB-1:IFB_GRP_LSB];

    // tag compare against every buffer each period
    for (genvar i = 0; i < IFB_NBUF; i++) begin : g_cmp
        assign match[i] = tvld_ff[i] && (tag_ff[i] == p_tag);
    end

    always_comb begin
        hit_idx = '0;
        for (int i = 0; i < IFB_NBUF; i++) begin
            if (match[i]) begin
                hit_idx = 2'(i);
            end
        end
    end

    assign hit = |match;
    assign grp_rdy = gok_ff[hit_idx][p_grp];
    assign sw_need = hit && (hit_idx != last_buf_ff);
    assign flush = BRANCH_TAKEN || XCHG_GO;
    // second parcel of a pending two-parcel goes to lower register
    assign to_lip = cip_vld_ff && CUR_TWO_PARCEL && !lip_vld_ff;
    // fetch into next only when it is empty, so decode is settled
    assign want = to_lip || !nip_vld_ff;
    assign fetch_go = want && hit && grp_rdy && !sw_need
        && (sw_cnt_ff == 2'h0) && !flush;
    // a pending invalidate goes first, so a freshly claimed tag is never wiped
    assign miss_go = want && !hit && ctrl_ff[IFB_CTRL_EN] && !inv_ff
        && (fsm_ff == IFB_IDLE) && !flush && !XCHG_ACTIVE;

    // issue waits for conflicts and for the second parcel
    assign ISSUE_GO = cip_vld_ff && !ISSUE_HOLD
        && (!CUR_TWO_PARCEL || lip_vld_ff);
    assign cip_take = nip_vld_ff && (!cip_vld_ff || ISSUE_GO) && !flush;

    // program address: data only, not cleared by master clear
    always_ff @(posedge REF_CLK) begin
        if (XCHG_GO) begin
            p_ff <= XCHG_P_IN;
        end else if (BRANCH_TAKEN) begin
            p_ff <= BRANCH_ADDR;
        end else if (fetch_go) begin
            p_ff <= p_ff + 24'h1;
        end
    end

    // parcel data registers; contents survive master clear
    always_ff @(posedge REF_CLK) begin
        if (fetch_go && !to_lip) begin
            next_parcel_reg <= mem_ff[{hit_idx, p_ff[IFB_TAG_LSB-1:0]}];
        end else if (ISSUE_GO && CUR_TWO_PARCEL) begin
            next_parcel_reg <= '0;
        end
        if (cip_take) begin
            current_parcel_reg <= next_parcel_reg;
        end
        if (fetch_go && to_lip) begin
            lower_parcel_reg <= mem_ff[{hit_idx, p_ff[IFB_TAG_LSB-1:0]}];
        end
    end

    // parcel flags: cleared by master clear and by a branch or exchange
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            nip_vld_ff <= 1'b0;
            cip_vld_ff <= 1'b0;
            lip_vld_ff <= 1'b0;
        end else if (flush) begin
            nip_vld_ff <= 1'b0;
            cip_vld_ff <= 1'b0;
            lip_vld_ff <= 1'b0;
        end else begin
            if (fetch_go && !to_lip) begin
                nip_vld_ff <= 1'b1;
            end else if (cip_take) begin
                nip_vld_ff <= 1'b0;
            end
            if (cip_take) begin
                cip_vld_ff <= 1'b1;
            end else if (ISSUE_GO) begin
                cip_vld_ff <= 1'b0;
            end
            if (fetch_go && to_lip) begin
                lip_vld_ff <= 1'b1;
            end else if (ISSUE_GO) begin
                lip_vld_ff <= 1'b0;
            end
        end
    end

    // buffer change penalty: hold off fetch for two periods
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sw_cnt_ff <= 2'h0;
            last_buf_ff <= 2'h0;
        end else if (want && sw_need && (sw_cnt_ff == 2'h0) && !flush) begin
            sw_cnt_ff <= IFB_SW_LOAD;
            last_buf_ff <= hit_idx;
        end else if (sw_cnt_ff != 2'h0) begin
            sw_cnt_ff <= sw_cnt_ff - 2'h1;
        end
    end

    // tags: a miss claims the rotation buffer before data lands
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tvld_ff <= '0;
            rot_ff <= 2'h0;
            for (int i = 0; i < IFB_NBUF; i++) begin
                tag_ff[i] <= '0;
                gok_ff[i] <= '0;
            end
        end else begin
            if (XCHG_GO || (inv_ff && fsm_ff == IFB_IDLE)) begin
                tvld_ff <= '0;
            end else if (miss_go) begin
                tag_ff[rot_ff] <= p_tag;
                tvld_ff[rot_ff] <= 1'b1;
                gok_ff[rot_ff] <= '0;
            end
            if (miss_go) begin
                rot_ff <= rot_ff + 2'h1;
            end
            if (MEM_RVALID && fsm_ff != IFB_IDLE) begin
                gok_ff[fbuf_ff][2'(fgrp_ff + rcnt_ff[1:0])] <= 1'b1;
            end
        end
    end

    // buffer storage: one group of parcels lands per period;
    // stores elsewhere never reach here, so old code stays put
    always_ff @(posedge REF_CLK) begin
        if (MEM_RVALID && fsm_ff != IFB_IDLE) begin
            for (int k = 0; k < IFB_GRP_N; k++) begin
                mem_ff[{fbuf_ff, 2'(fgrp_ff + rcnt_ff[1:0]), 5'(k)}]
                    <= MEM_RDATA[k*IFB_PCL_W +: IFB_PCL_W];
            end
        end
    end

    // refill sequencer: wait busy, four group requests, four returns
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fsm_ff <= IFB_IDLE;
            fbuf_ff <= 2'h0;
            fgrp_ff <= 2'h0;
            ftag_ff <= '0;
            qcnt_ff <= 3'h0;
            rcnt_ff <= 3'h0;
            mem_req_ff <= 1'b0;
            mem_addr_ff <= '0;
        end else begin
            case (fsm_ff)
                IFB_IDLE: begin
                    if (miss_go) begin
                        fbuf_ff <= rot_ff;
                        fgrp_ff <= p_grp;
                        ftag_ff <= p_tag;
                        fsm_ff <= IFB_WAIT;
                    end
                end
                IFB_WAIT: begin
                    if (!MEM_BUSY) begin
                        mem_req_ff <= 1'b1;
                        mem_addr_ff <= {ftag_ff, fgrp_ff, IFB_GRP_WLO};
                        qcnt_ff <= 3'h1;
                        rcnt_ff <= 3'h0;
                        fsm_ff <= IFB_REQ;
                    end
                end
                IFB_REQ: begin
                    if (qcnt_ff > IFB_LAST_GRP) begin
                        mem_req_ff <= 1'b0;
                        fsm_ff <= IFB_FILL;
                    end else begin
                        // circular wrap through the four groups
                        mem_addr_ff <= {ftag_ff, 2'(fgrp_ff + qcnt_ff[1:0]),
                            IFB_GRP_WLO};
                        qcnt_ff <= qcnt_ff + 3'h1;
                    end
                end
                IFB_FILL: begin
                    if (MEM_RVALID && rcnt_ff == IFB_LAST_GRP) begin
                        fsm_ff <= IFB_IDLE;
                    end
                end
                default: fsm_ff <= IFB_IDLE;
            endcase
            if (MEM_RVALID && fsm_ff != IFB_IDLE) begin
                rcnt_ff <= rcnt_ff + 3'h1;
            end
        end
    end

    // latency monitor: flags a first group slower than nominal
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lat_ff <= 8'h0;
            late_ff <= 1'b0;
        end else if (fsm_ff == IFB_WAIT && !MEM_BUSY) begin
            lat_ff <= 8'h1;
        end else if (MEM_RVALID && rcnt_ff == 3'h0 && fsm_ff != IFB_IDLE) begin
            late_ff <= (int'(lat_ff) > FETCH_CP);
        end else if (lat_ff != 8'hff) begin
            lat_ff <= lat_ff + 8'h1;
        end
    end

    // outputs
    assign CUR_PARCEL = current_parcel_reg;
    assign LOW_PARCEL = lower_parcel_reg;
    assign CUR_VALID = cip_vld_ff;
    assign XCHG_P_OUT = p_ff;
    assign LOCKOUT = (fsm_ff != IFB_IDLE) || XCHG_ACTIVE;
    assign MEM_REQ = mem_req_ff;
    assign MEM_ADDR = mem_addr_ff;

    // axi write: address and data taken in either order
    assign S_AXI_AWREADY = !aw_ok_ff && !bvalid_ff;
    assign S_AXI_WREADY = !w_ok_ff && !bvalid_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign wr_go = aw_ok_ff && w_ok_ff && !bvalid_ff;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            aw_addr_ff <= 4'h0;
            wdata_ff <= 32'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_ok_ff <= 1'b1;
                aw_addr_ff <= S_AXI_AWADDR;
            end else if (wr_go) begin
                aw_ok_ff <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_ok_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
            end else if (wr_go) begin
                w_ok_ff <= 1'b0;
            end
        end
    end

    // control register; invalidate bit is a self-clearing request
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_ff <= IFB_CTRL_RST;
            inv_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= IFB_RESP_OK;
        end else begin
            if (inv_ff && fsm_ff == IFB_IDLE) begin
                inv_ff <= 1'b0;
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                if (aw_addr_ff == IFB_REG_CTRL) begin
                    bresp_ff <= IFB_RESP_OK;
                    if (S_AXI_WSTRB[0]) begin
                        ctrl_ff[IFB_CTRL_EN] <= wdata_ff[IFB_CTRL_EN];
                        inv_ff <= inv_ff | wdata_ff[IFB_CTRL_INV];
                    end
                end else if (aw_addr_ff == IFB_REG_STAT || aw_addr_ff == IFB_REG_PADR) begin
                    bresp_ff <= IFB_RESP_OK;
                end else begin
                    bresp_ff <= IFB_RESP_ERR;
                end
            end else if (bvalid_ff && S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // axi read: one cycle to data, held until rready
    assign S_AXI_ARREADY = !rvalid_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign S_AXI_RRESP = rresp_ff;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= IFB_RESP_OK;
        end else if (S_AXI_ARVALID && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= IFB_RESP_OK;
            if (S_AXI_ARADDR == IFB_REG_CTRL) begin
                rdata_ff <= ctrl_ff & IFB_CTRL_RST;
            end else if (S_AXI_ARADDR == IFB_REG_STAT) begin
                rdata_ff <= {18'h0, tvld_ff, late_ff, rot_ff,
                    fsm_ff, lip_vld_ff, cip_vld_ff, nip_vld_ff,
                    LOCKOUT, hit};
            end else if (S_AXI_ARADDR == IFB_REG_PADR) begin
                rdata_ff <= {8'h0, p_ff};
            end else begin
                rdata_ff <= 32'h0;
                rresp_ff <= IFB_RESP_ERR;
            end
        end else if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence sw_hold_s;
        !fetch_go ##1 !fetch_go;
    endsequence

    p_advance_a: assert property (fetch_go |=> p_ff == $past(p_ff) + 24'h1)
        else $error("address did not advance");
    cip_source_a: assert property (cip_take |=> current_parcel_reg == $past(next_parcel_reg))
        else $error("current parcel not from next");
    sw_delay_a: assert property (want && sw_need && sw_cnt_ff == 2'h0 && !flush |-> sw_hold_s)
        else $error("buffer change not delayed");
    one_match_a: assert property ($onehot0(match))
        else $error("parcel held in two buffers");
    rot_step_a: assert property (miss_go |=> rot_ff == $past(rot_ff) + 2'h1 ##1 fsm_ff != IFB_IDLE)
        else $error("rotation counter not stepped");
    xchg_void_a: assert property (XCHG_GO |=> tvld_ff == '0)
        else $error("exchange left buffer valid");
    lock_fetch_a: assert property (fsm_ff != IFB_IDLE |-> LOCKOUT)
        else $error("fetch without lockout");
    busy_wait_a: assert property (fsm_ff == IFB_WAIT && MEM_BUSY |=> !mem_req_ff)
        else $error("request while memory busy");
    tag_load_a: assert property (miss_go |=> tag_ff[fbuf_ff] == $past(p_tag))
        else $error("tag not loaded on refill");
    miss_stall_a: assert property (!hit |-> !fetch_go)
        else $error("fetch with no buffer match");
endmodule : ifb_top

/* ifb_pkg.sv */
package ifb_pkg;
    // address and parcel geometry
    localparam int IFB_PA_W = 24;
    localparam int IFB_WA_W = 22;
    localparam int IFB_TAG_W = 17;
    localparam int IFB_TAG_LSB = 7;
    localparam int IFB_GRP_LSB = 5;
    localparam int IFB_PCL_W = 16;
    localparam int IFB_NBUF = 4;
    localparam int IFB_DEPTH = 128;
    localparam int IFB_GRP_N = 32;
    localparam int IFB_NGRP = 4;
    localparam logic [2:0] IFB_GRP_WLO = 3'h0;
    localparam logic [2:0] IFB_LAST_GRP = 3'h3;
    // buffer change costs two clock periods; counter loads one less
    localparam int IFB_SW_CP = 2;
    localparam logic [1:0] IFB_SW_LOAD = 2'(IFB_SW_CP - 1);
    // out-of-buffer branch time with idle 64-bank memory
    localparam int IFB_FETCH_CP = 16;
    // register map
    localparam logic [3:0] IFB_REG_CTRL = 4'h0;
    localparam logic [3:0] IFB_REG_STAT = 4'h4;
    localparam logic [3:0] IFB_REG_PADR = 4'h8;
    localparam int IFB_CTRL_EN = 0;
    localparam int IFB_CTRL_INV = 1;
    localparam logic [31:0] IFB_CTRL_RST = 32'h0000_0001;
    localparam logic [1:0] IFB_RESP_OK = 2'h0;
    localparam logic [1:0] IFB_RESP_ERR = 2'h2;
    // refill sequencer
    typedef enum logic [1:0] {
        IFB_IDLE = 2'b00,
        IFB_WAIT = 2'b01,
        IFB_REQ = 2'b10,
        IFB_FILL = 2'b11
    } ifb_fsm_e;
endpackage : ifb_pkg

/* ifb_mem_model.sv */
module ifb_mem_model import ifb_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mem_req,
    input wire logic [IFB_WA_W-1:0] mem_addr,
    input wire logic [7:0] gen,
    input wire logic [1:0] lat,
    input wire logic hold_busy,
    output logic mem_busy,
    output logic mem_rvalid,
    output logic [IFB_GRP_N*IFB_PCL_W-1:0] mem_rdata
);
    int unsigned cyc;
    logic [IFB_WA_W-1:0] q_a[$];
    int unsigned q_t[$];
    logic [IFB_PA_W-1:0] pa;

    // parcel content follows address and store generation, so stale copies show
    function automatic logic [15:0] pcl(input logic [23:0] x, input logic [7:0] g);
        return {x[0] ^ x[3] ^ x[9], x[14:0]} ^ {g, g};
    endfunction : pcl

    // groups answer strictly in request order, each after its latency
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_a.delete();
            q_t.delete();
            cyc = 0;
            mem_busy <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata <= '0;
        end else begin
            cyc++;
            mem_busy <= hold_busy;
            if (mem_req === 1'b1) begin
                q_a.push_back(mem_addr);
                q_t.push_back(cyc + lat);
            end
            if (q_t.size() > 0 && q_t[0] < cyc) begin
                pa = {q_a.pop_front(), 2'b00};
                void'(q_t.pop_front());
                for (int k = 0; k < IFB_GRP_N; k++) begin
                    mem_rdata[k*IFB_PCL_W +: IFB_PCL_W] <= pcl(pa + 24'(k), gen);
                end
                mem_rvalid <= 1'b1;
            end else begin
                // idle bus toggles so a late sample never looks like good data
                mem_rdata <= ~mem_rdata;
                mem_rvalid <= 1'b0;
            end
        end
    end
endmodule : ifb_mem_model

/* tb.sv */
module tb import ifb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK = 1'b0;
    logic RST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
    logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic CUR_TWO_PARCEL, ISSUE_HOLD, ISSUE_GO, CUR_VALID, BRANCH_TAKEN, XCHG_GO;
    logic XCHG_ACTIVE, LOCKOUT, MEM_BUSY, MEM_REQ, MEM_RVALID;
    logic [3:0] S_AXI_AWADDR, S_AXI_WSTRB, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, lat, rsp;
    logic [IFB_PCL_W-1:0] CUR_PARCEL, LOW_PARCEL;
    logic [IFB_PA_W-1:0] BRANCH_ADDR, XCHG_P_IN, XCHG_P_OUT, ptr, a;
    logic [IFB_WA_W-1:0] MEM_ADDR, last, exp_a;
    logic [IFB_GRP_N*IFB_PCL_W-1:0] MEM_RDATA;
    logic [31:0] seed = 32'h7c79774b;
    logic [7:0] gen;
    logic two_en, hold_busy, exp_first, req_d, busy_d;
    int errors, checks, nis, nref, cyc;
    int bgen[int];

    ifb_top u_dut (
        .REF_CLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
        .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
        .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .CUR_TWO_PARCEL, .ISSUE_HOLD,
        .ISSUE_GO, .CUR_PARCEL, .LOW_PARCEL, .CUR_VALID, .BRANCH_TAKEN, .BRANCH_ADDR,
        .XCHG_GO, .XCHG_ACTIVE, .XCHG_P_IN, .XCHG_P_OUT, .LOCKOUT, .MEM_BUSY, .MEM_REQ,
        .MEM_ADDR, .MEM_RVALID, .MEM_RDATA
    );
    ifb_mem_model u_mem (.clk(REF_CLK), .rst_n(RST_N), .mem_req(MEM_REQ), .mem_addr(MEM_ADDR),
        .gen(gen), .lat(lat), .hold_busy(hold_busy), .mem_busy(MEM_BUSY),
        .mem_rvalid(MEM_RVALID), .mem_rdata(MEM_RDATA));

    always #5 REF_CLK = ~REF_CLK;

    // decode stand-in: top bit of a valid current parcel marks a two-parcel instruction
    assign CUR_TWO_PARCEL = two_en && (CUR_VALID === 1'b1) && (CUR_PARCEL[15] === 1'b1);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [15:0] pcl(input logic [23:0] x, input logic [7:0] g);
        return {x[0] ^ x[3] ^ x[9], x[14:0]} ^ {g, g};
    endfunction : pcl

    // expected parcel uses the generation present when its buffer was filled
    function automatic logic [15:0] ep(input logic [23:0] x);
        return pcl(x, 8'(bgen[int'(x[23:7])]));
    endfunction : ep

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic axw(input logic [3:0] ad, input logic [31:0] d, output logic [1:0] r);
        @(posedge REF_CLK);
        S_AXI_AWADDR <= ad;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge REF_CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask : axw

    task automatic axr(input logic [3:0] ad, output logic [31:0] d, output logic [1:0] r);
        @(posedge REF_CLK);
        S_AXI_ARADDR <= ad;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge REF_CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask : axr

    // hold issue until no refill has been under way for twelve cycles
    task automatic quiet();
        int n;
        n = 0;
        @(posedge REF_CLK);
        ISSUE_HOLD <= 1'b1;
        hold_busy <= 1'b0;
        while (n < 12) begin
            @(posedge REF_CLK);
            n = (LOCKOUT === 1'b0) ? n + 1 : 0;
        end
    endtask : quiet

    // decode style only changes with a flush, never under a loaded instruction
    task automatic jump(input logic [23:0] x);
        @(posedge REF_CLK);
        BRANCH_ADDR <= x;
        BRANCH_TAKEN <= 1'b1;
        two_en <= 1'(rnd());
        @(posedge REF_CLK);
        BRANCH_TAKEN <= 1'b0;
    endtask : jump

    task automatic run(input int n);
        int t;
        t = nis + n;
        lat <= 2'(rnd());
        while (nis < t) begin
            @(posedge REF_CLK);
            ISSUE_HOLD <= (rnd() % 4) == 0;
            hold_busy <= (rnd() % 8) == 0;
        end
    endtask : run

    // exchange with the sequence held active, inspect, then let it refill
    task automatic xtest(input logic [23:0] x);
        @(posedge REF_CLK);
        XCHG_ACTIVE <= 1'b1;
        XCHG_P_IN <= x;
        XCHG_GO <= 1'b1;
        two_en <= 1'(rnd());
        @(posedge REF_CLK);
        XCHG_GO <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        chk("lockout", 1, 32'(LOCKOUT));
        axw(IFB_REG_PADR, 32'(~x), rsp);
        axw(4'hc, 32'(~x), rsp);
        chk("unmapped_bresp", 32'(IFB_RESP_ERR), 32'(rsp));
        axr(IFB_REG_PADR, rd, rsp);
        chk("padr", 32'(x), rd);
        chk("p_out", 32'(x), 32'(XCHG_P_OUT));
        axr(IFB_REG_STAT, rd, rsp);
        chk("buf_valid", 0, 32'(rd[13:10]));
        chk("hit", 0, 32'(rd[0]));
        exp_a = {x[23:7], x[6:5], 3'h0};
        exp_first = 1'b1;
        XCHG_ACTIVE <= 1'b0;
        run(20);
        chk("refilled", 0, 32'(exp_first));
        $display("done: exchange to %h", x);
    endtask : xtest

    // reference model: issue order from the program address, refill group order
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            complete_run();
        end
        if (RST_N === 1'b1 && ISSUE_GO === 1'b1) begin
            chk("cur_parcel", 32'(ep(ptr)), 32'(CUR_PARCEL));
            if (CUR_TWO_PARCEL) begin
                chk("low_parcel", 32'(ep(ptr + 24'd1)), 32'(LOW_PARCEL));
                ptr = ptr + 24'd1;
            end
            ptr = ptr + 24'd1;
            nis++;
        end
        if (BRANCH_TAKEN === 1'b1) ptr = BRANCH_ADDR;
        if (XCHG_GO === 1'b1) ptr = XCHG_P_IN;
        if (MEM_REQ === 1'b1 && req_d !== 1'b1) begin
            chk("busy_before_req", 0, 32'(busy_d));
            if (exp_first) chk("first_group", 32'(exp_a), 32'(MEM_ADDR));
            exp_first = 1'b0;
            bgen[int'(MEM_ADDR[21:5])] = gen;
            nref++;
        end else if (MEM_REQ === 1'b1) begin
            chk("next_group", 32'({last[21:5], last[4:3] + 2'd1, 3'h0}), 32'(MEM_ADDR));
        end
        last = MEM_ADDR;
        req_d = MEM_REQ;
        busy_d = MEM_BUSY;
    end

    initial begin
        int n0;
        RST_N = 1'b0;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
        {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, BRANCH_ADDR, XCHG_P_IN} = '0;
        {BRANCH_TAKEN, XCHG_GO, hold_busy, two_en, exp_first} = '0;
        // program address is unknown until the first exchange, so hold off refills
        XCHG_ACTIVE = 1'b1;
        {req_d, busy_d, gen, lat} = '0;
        S_AXI_WSTRB = 4'hf;
        ISSUE_HOLD = 1'b1;
        repeat (6) @(posedge REF_CLK);
        chk("rst_cur_valid", 0, 32'(CUR_VALID));
        chk("rst_mem_req", 0, 32'(MEM_REQ));
        RST_N <= 1'b1;
        axr(IFB_REG_CTRL, rd, rsp);
        chk("ctrl_reset", IFB_CTRL_RST, rd);
        axr(4'hc, rd, rsp);
        chk("unmapped_rresp", 32'(IFB_RESP_ERR), 32'(rsp));
        xtest({4'h0, 20'(rnd())});
        // fresh regions in turn: needed group first, rotation advances per refill
        for (int i = 1; i <= 5; i++) begin
            quiet();
            a = {4'(i), 20'(rnd())};
            exp_a = {a[23:7], a[6:5], 3'h0};
            exp_first = 1'b1;
            jump(a);
            run(24);
            quiet();
            axr(IFB_REG_STAT, rd, rsp);
            chk("rotation", 32'(nref % 4), 32'(rd[8:7]));
            chk("late", 0, 32'(rd[9]));
            $display("done: refill region %0d", i);
        end
        chk("all_valid", 32'hf, 32'(rd[13:10]));
        // memory changes underneath; a buffered branch keeps the old parcels
        gen <= gen + 8'd1;
        quiet();
        n0 = nref;
        jump({a[23:7], 7'h00});
        run(16);
        chk("no_reload", n0, nref);
        $display("done: buffered branch");
        xtest({a[23:7], 7'h10});
        // refill disabled: a miss must stall with nothing fetched
        axw(IFB_REG_CTRL, 32'h0, rsp);
        quiet();
        n0 = nref;
        a = 24'h9a0040;
        exp_a = {a[23:7], a[6:5], 3'h0};
        exp_first = 1'b1;
        jump(a);
        repeat (40) @(posedge REF_CLK);
        chk("no_refill", n0, nref);
        chk("stalled", 0, 32'(CUR_VALID));
        axw(IFB_REG_CTRL, 32'(1 << IFB_CTRL_EN), rsp);
        run(20);
        chk("resumed", 0, 32'(exp_first));
        $display("done: refill disable");
        // invalidate request with refill off: every buffer tag drops
        quiet();
        axw(IFB_REG_CTRL, 32'(1 << IFB_CTRL_INV), rsp);
        axr(IFB_REG_STAT, rd, rsp);
        chk("inv_valid", 0, 32'(rd[13:10]));
        $display("done: invalidate");
        // master clear in mid-run: flags drop, program address survives
        quiet();
        axr(IFB_REG_PADR, rd, rsp);
        a = rd[23:0];
        RST_N <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        chk("clr_cur_valid", 0, 32'(CUR_VALID));
        chk("clr_issue", 0, 32'(ISSUE_GO));
        RST_N <= 1'b1;
        axr(IFB_REG_PADR, rd, rsp);
        chk("padr_kept", 32'(a), rd);
        $display("done: master clear");
        xtest({4'h7, 20'(rnd())});
        complete_run();
    end
endmodule : tb
